// ==== shared/rsc_pkg.sv ====
// Constants for the reset source combiner: register map, field layout, reset values.
// Assumes a 32-bit AXI4-Lite register bus and a single system clock.
package rsc_pkg;

    // Bus geometry
    localparam int RSC_ADDR_W = 8;
    localparam int RSC_DATA_W = 32;
    localparam int RSC_REG_W = 16;

    // Register byte offsets
    localparam logic [RSC_ADDR_W-1:0] RSC_OFS_STATUS_CONTROL = 8'h00;
    localparam logic [RSC_ADDR_W-1:0] RSC_OFS_LIVE_SOURCES = 8'h04;

    // Field positions inside the status/control register
    localparam int RSC_BIT_POWER_ON = 0;
    localparam int RSC_BIT_BROWN_OUT = 1;
    localparam int RSC_BIT_IDLE_WAKE = 2;
    localparam int RSC_BIT_SLEEP_WAKE = 3;
    localparam int RSC_BIT_WDOG_TIMEOUT = 4;
    localparam int RSC_BIT_WDOG_SOFT_EN = 5;
    localparam int RSC_BIT_SOFTWARE = 6;
    localparam int RSC_BIT_EXT_PIN = 7;
    localparam int RSC_BIT_REG_SLEEP_ACT = 8;
    localparam int RSC_BIT_CONFIG_MISMATCH = 9;
    localparam int RSC_BIT_ILLEGAL = 14;
    localparam int RSC_BIT_TRAP = 15;

    // Implemented bits, power-on value, and the control (non-status) bits
    localparam logic [RSC_REG_W-1:0] RSC_IMPL_MASK = 16'hc3ff;
    localparam logic [RSC_REG_W-1:0] RSC_POR_VALUE = 16'h0003;
    localparam logic [RSC_REG_W-1:0] RSC_CTRL_MASK = 16'h0120;

    // Live source register width (one bit per source)
    localparam int RSC_NUM_SRC = 10;

    // AXI response codes
    localparam logic [1:0] RSC_RESP_OKAY = 2'h0;
    localparam logic [1:0] RSC_RESP_SLVERR = 2'h2;

    // Sequencer states, one-hot
    typedef enum logic [1:0] {
        RSC_ST_RUN = 2'h1,
        RSC_ST_RESET = 2'h2
    } rsc_state_t;

endpackage

// ==== shared/rsc_reg_if.sv ====
// Register access carrier between the bus slave and the combiner core.
// Assumes both ends run on the same clock; strobes are one-cycle pulses.
`timescale 1ns/1ps
interface rsc_reg_if;
    import rsc_pkg::*;
    logic wr; // Write strobe
    logic [RSC_ADDR_W-1:0] wr_addr; // Write byte address
    logic [RSC_DATA_W-1:0] wr_data; // Write data
    logic [3:0] wr_strb; // Byte enables
    logic wr_err; // Write address unmapped
    logic rd; // Read strobe
    logic [RSC_ADDR_W-1:0] rd_addr; // Read byte address
    logic [RSC_DATA_W-1:0] rd_data; // Read data, combinational
    logic rd_err; // Read address unmapped

    modport bus (output wr, wr_addr, wr_data, wr_strb, rd, rd_addr, input wr_err, rd_data, rd_err);
    modport regs (input wr, wr_addr, wr_data, wr_strb, rd, rd_addr, output wr_err, rd_data, rd_err);
endinterface

// ==== hw/rsc_src_sync.sv ====
// Two-flop synchroniser bank for inputs arriving from outside the clock domain.
// Assumes each bit is a slow level; a pulse shorter than one clock may be lost.
`timescale 1ns/1ps
module rsc_src_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q; // First stage, read only by the second stage

    ////////////////////////////////////////////////////////////////////////
    // One synchroniser per bit
    genvar gi;
    generate
        for (gi = 0; gi < W; gi++) begin : g_bit
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    meta_q[gi] <= INIT[gi];
                    sync_out[gi] <= INIT[gi];
                end else begin
                    meta_q[gi] <= async_in[gi];
                    sync_out[gi] <= meta_q[gi];
                end
            end
        end
    endgenerate
endmodule

// ==== hw/rsc_axil_slave.sv ====
// AXI4-Lite slave front end: accepts one write and one read at a time.
// Assumes the register core answers reads combinationally in the strobe cycle.
`timescale 1ns/1ps
module rsc_axil_slave
    import rsc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [RSC_ADDR_W-1:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [RSC_DATA_W-1:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [RSC_ADDR_W-1:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [RSC_DATA_W-1:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    rsc_reg_if.bus rif
);
    logic aw_held_q; // Write address captured
    logic w_held_q; // Write data captured
    logic [RSC_ADDR_W-1:0] awaddr_q; // Captured write address
    logic [RSC_DATA_W-1:0] wdata_q; // Captured write data
    logic [3:0] wstrb_q; // Captured byte enables

    // Write ready while the holding slot is free, read ready while no read response is pending
    assign s_awready = !aw_held_q;
    assign s_wready = !w_held_q;
    assign s_arready = !s_rvalid;

    // Perform the write once both halves are held and no response is pending
    assign rif.wr = aw_held_q && w_held_q && !s_bvalid;
    assign rif.wr_addr = awaddr_q;
    assign rif.wr_data = wdata_q;
    assign rif.wr_strb = wstrb_q;
    assign rif.rd = s_arvalid && !s_rvalid;
    assign rif.rd_addr = s_araddr;

    ////////////////////////////////////////////////////////////////////////
    // Write address and data capture, in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else if (rif.wr) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
        end else begin
            if (s_awvalid && !aw_held_q) begin
                aw_held_q <= 1'b1;
                awaddr_q <= s_awaddr;
            end
            if (s_wvalid && !w_held_q) begin
                w_held_q <= 1'b1;
                wdata_q <= s_wdata;
                wstrb_q <= s_wstrb;
            end
        end
    end

    // Write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_bvalid <= 1'b0;
            s_bresp <= RSC_RESP_OKAY;
        end else if (rif.wr) begin
            s_bvalid <= 1'b1;
            s_bresp <= rif.wr_err ? RSC_RESP_SLVERR : RSC_RESP_OKAY;
        end else if (s_bready) begin
            s_bvalid <= 1'b0;
        end
    end

    // Read data and response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_rvalid <= 1'b0;
            s_rdata <= '0;
            s_rresp <= RSC_RESP_OKAY;
        end else if (rif.rd) begin
            s_rvalid <= 1'b1;
            s_rdata <= rif.rd_data;
            s_rresp <= rif.rd_err ? RSC_RESP_SLVERR : RSC_RESP_OKAY;
        end else if (s_rready) begin
            s_rvalid <= 1'b0;
        end
    end
endmodule

// ==== hw/rsc_reset_combiner.sv ====
// Reset source combiner: merges all reset sources into one system reset,
// records the cause in a software-visible status/control register.
// Assumes aresetn is the power-on reset; core event inputs share aclk.
//
// How it works
// - Any active source asserts system reset
// - Combine power, brown-out, pin, software, watchdog, mismatch, trap
// - Each reset kind sets its own flag
// - Power-on clears flags, sets power-on and brown-out flags
// - Software writes flags, never causing reset
// - Bit 15 flags trap conflict reset
// - Bit 14 flags illegal opcode/address/uninit register
// - Bit 9 flags configuration mismatch reset
// - Bit 8 keeps regulator active in sleep
// - Bit 7 flags master clear pin reset
// - Bit 6 flags software reset instruction
// - Bit 5 enables watchdog; fuse forces on
// - Bit 4 flags watchdog time-out
// - Bit 3 flags wake from sleep
// - Bit 2 flags wake from idle
// - Bits 13 to 10 read zero
// - System reset forces defined control values
// - Bit 1 flags brown-out reset
// - Bit 0 flags power-on reset
`timescale 1ns/1ps
module rsc_reset_combiner
    import rsc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,

    // Pin-side sources and watchdog fuse level
    input wire logic master_clear_pin_n,
    input wire logic brown_out_detect,
    input wire logic watchdog_fuse_enable,

    // Core events
    input wire logic sw_reset_instr,
    input wire logic watchdog_timeout,
    input wire logic config_mismatch,
    input wire logic trap_conflict,
    input wire logic illegal_opcode,
    input wire logic illegal_addr_mode,
    input wire logic uninit_wreg,
    input wire logic security_violation,

    // Low-power entry
    input wire logic sleep_entered,
    input wire logic idle_entered,

    // Register bus
    input wire logic [RSC_ADDR_W-1:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,

    input wire logic [RSC_DATA_W-1:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,

    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,

    input wire logic [RSC_ADDR_W-1:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,

    output logic [RSC_DATA_W-1:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,

    // Outputs
    output logic system_reset,
    output logic watchdog_enable,
    output logic regulator_sleep_active
);

    ////////////////////////////////////////////////////////////////////////
    // Address decode helpers, shared by the write and read paths

    // True when the address selects the status/control register
    function automatic logic is_status_control(input logic [RSC_ADDR_W-1:0] addr);
        is_status_control = (addr == RSC_OFS_STATUS_CONTROL);
    endfunction

    // True when the address selects the live source register
    function automatic logic is_live_sources(input logic [RSC_ADDR_W-1:0] addr);
        is_live_sources = (addr == RSC_OFS_LIVE_SOURCES);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    rsc_reg_if rif(); // Bus-to-core register carrier

    localparam int PIN_N = 3; // Inputs coming from outside the clock domain
    localparam logic [PIN_N-1:0] PIN_INIT = 3'h1; // Pin idles high, others low

    logic [PIN_N-1:0] pin_sync; // Synchronised pin-side inputs
    logic master_clear_pin_active; // Master clear pin held low
    logic brown_out_active; // Supply below brown-out threshold
    logic fuse_wdog_on; // Watchdog fuse unprogrammed, forces watchdog on

    logic illegal_any; // Any illegal-condition event
    logic [RSC_NUM_SRC-1:0] live_src; // All reset sources but power-on, one bit each
    logic any_source; // At least one reset source active

    logic [RSC_REG_W-1:0] status_control_q; // Status/control register
    logic [RSC_REG_W-1:0] status_control_d; // Its next value
    logic [RSC_REG_W-1:0] hw_set; // Flags hardware sets this cycle
    logic [RSC_REG_W-1:0] wr_mask; // Bits touched by a software write
    logic [RSC_REG_W-1:0] wr_val; // Write data aligned to the register
    logic sc_write; // Software write to status/control this cycle

    rsc_state_t state_q; // Sequencer state
    rsc_state_t state_d; // Its next value
    logic system_reset_q; // Registered system reset

    ////////////////////////////////////////////////////////////////////////
    // Bus front end and pin synchronisers

    rsc_axil_slave u_slave (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_awaddr(s_awaddr),
        .s_awvalid(s_awvalid),
        .s_awready(s_awready),

        .s_wdata(s_wdata),
        .s_wstrb(s_wstrb),
        .s_wvalid(s_wvalid),
        .s_wready(s_wready),

        .s_bresp(s_bresp),
        .s_bvalid(s_bvalid),
        .s_bready(s_bready),

        .s_araddr(s_araddr),
        .s_arvalid(s_arvalid),
        .s_arready(s_arready),

        .s_rdata(s_rdata),
        .s_rresp(s_rresp),
        .s_rvalid(s_rvalid),
        .s_rready(s_rready),
        .rif(rif.bus)
    );

    // Pin, brown-out comparator and fuse level all come from outside aclk
    rsc_src_sync #(
        .W(PIN_N),
        .INIT(PIN_INIT)
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in({watchdog_fuse_enable, brown_out_detect, master_clear_pin_n}),
        .sync_out(pin_sync)
    );

    assign master_clear_pin_active = !pin_sync[0];
    assign brown_out_active = pin_sync[1];
    assign fuse_wdog_on = pin_sync[2];

    ////////////////////////////////////////////////////////////////////////
    // Source combining

    // Illegal opcode, illegal addressing, uninitialised register, security
    assign illegal_any = illegal_opcode | illegal_addr_mode | uninit_wreg | security_violation;

    // Power-on source is aresetn itself; the rest are collected here
    assign live_src = {security_violation, uninit_wreg, illegal_addr_mode, illegal_opcode,
                       trap_conflict, config_mismatch, watchdog_timeout, sw_reset_instr,
                       master_clear_pin_active, brown_out_active};

    // Any single source is enough; software register writes are not sources
    assign any_source = |live_src;

    ////////////////////////////////////////////////////////////////////////
    // Reset sequencer

    // Next state: enter reset on any source, leave once all are gone
    always_comb begin
        state_d = state_q;

        case (state_q)
            RSC_ST_RUN: begin
                if (any_source) begin
                    state_d = RSC_ST_RESET;
                end
            end

            RSC_ST_RESET: begin
                if (!any_source) begin
                    state_d = RSC_ST_RUN;
                end
            end

            default: begin
                state_d = RSC_ST_RESET;
            end
        endcase
    end

    // State register; power-on holds the system in reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= RSC_ST_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // Registered reset output, asserted throughout power-on too
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            system_reset_q <= 1'b1;
        end else begin
            system_reset_q <= (state_d == RSC_ST_RESET);
        end
    end

    assign system_reset = system_reset_q;

    ////////////////////////////////////////////////////////////////////////
    // Status/control register

    // Hardware flag sets, one per reset kind and per low-power wake
    always_comb begin
        hw_set = '0;
        hw_set[RSC_BIT_TRAP] = trap_conflict;
        hw_set[RSC_BIT_ILLEGAL] = illegal_any;
        hw_set[RSC_BIT_CONFIG_MISMATCH] = config_mismatch;
        hw_set[RSC_BIT_EXT_PIN] = master_clear_pin_active;
        hw_set[RSC_BIT_SOFTWARE] = sw_reset_instr;
        hw_set[RSC_BIT_WDOG_TIMEOUT] = watchdog_timeout;

        // Wake flags, then brown-out
        hw_set[RSC_BIT_SLEEP_WAKE] = sleep_entered;
        hw_set[RSC_BIT_IDLE_WAKE] = idle_entered;
        hw_set[RSC_BIT_BROWN_OUT] = brown_out_active;
    end

    // Software write qualification and byte-lane mask
    assign sc_write = rif.wr && is_status_control(rif.wr_addr);
    assign wr_mask = {{8{rif.wr_strb[1]}}, {8{rif.wr_strb[0]}}} & RSC_IMPL_MASK;
    assign wr_val = rif.wr_data[RSC_REG_W-1:0];

    // Next value: software write merged per lane, then hardware sets on top
    always_comb begin
        status_control_d = status_control_q;

        if (sc_write) begin
            status_control_d = (status_control_q & ~wr_mask) | (wr_val & wr_mask);
        end

        if (system_reset_q) begin
            status_control_d = status_control_d & ~RSC_CTRL_MASK;
        end

        status_control_d = (status_control_d | hw_set) & RSC_IMPL_MASK;
    end

    // Power-on loads the power-on flag alone plus brown-out, all else clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_control_q <= RSC_POR_VALUE;
        end else begin
            status_control_q <= status_control_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control outputs

    // Fuse unprogrammed keeps the watchdog on whatever software writes
    assign watchdog_enable = fuse_wdog_on | status_control_q[RSC_BIT_WDOG_SOFT_EN];

    // High keeps the regulator running in sleep, low lets it stand by
    assign regulator_sleep_active = status_control_q[RSC_BIT_REG_SLEEP_ACT];

    ////////////////////////////////////////////////////////////////////////
    // Register reads and decode errors

    // Read mux: unused upper bits read zero, unmapped reads return zero
    always_comb begin
        rif.rd_data = '0;

        if (rif.rd && is_status_control(rif.rd_addr)) begin
            rif.rd_data[RSC_REG_W-1:0] = status_control_q;
        end else if (rif.rd && is_live_sources(rif.rd_addr)) begin
            rif.rd_data[RSC_NUM_SRC-1:0] = live_src;
        end
    end

    // Live source register is read-only; writes to it answer OKAY and are dropped
    assign rif.rd_err = !(is_status_control(rif.rd_addr) || is_live_sources(rif.rd_addr));
    assign rif.wr_err = !(is_status_control(rif.wr_addr) || is_live_sources(rif.wr_addr));

endmodule

// ==== tb/rsc_src_model.sv ====
// Model of the reset sources and core status lines facing the combiner.
// Assumes the bench drives one request bit per source, changed after an edge.
`timescale 1ns/1ps
module rsc_src_model (
    input wire logic [12:0] req,
    output logic master_clear_pin_n,
    output logic brown_out_detect,
    output logic sw_reset_instr,
    output logic watchdog_timeout,
    output logic config_mismatch,
    output logic trap_conflict,
    output logic illegal_opcode,
    output logic illegal_addr_mode,
    output logic uninit_wreg,
    output logic security_violation,
    output logic sleep_entered,
    output logic idle_entered,
    output logic watchdog_fuse_enable
);
    // Pin is active low; all other lines are active high levels
    assign master_clear_pin_n = ~req[0];
    assign {idle_entered, sleep_entered, security_violation, uninit_wreg, illegal_addr_mode} = req[11:7];
    assign {illegal_opcode, trap_conflict, config_mismatch, watchdog_timeout, sw_reset_instr} = req[6:2];
    assign brown_out_detect = req[1];
    assign watchdog_fuse_enable = req[12];
endmodule

// ==== tb/rsc_reset_combiner_properties.sv ====
// Checker on the combiner top ports: reset merging and readback shape.
// Assumes a single clock and aresetn as the power-on reset.
`timescale 1ns/1ps
module rsc_checker
    import rsc_pkg::*;
(
    input logic aclk,
    input logic aresetn,
    input logic master_clear_pin_n,
    input logic brown_out_detect,
    input logic watchdog_fuse_enable,
    input logic sw_reset_instr,
    input logic watchdog_timeout,
    input logic config_mismatch,
    input logic trap_conflict,
    input logic illegal_opcode,
    input logic illegal_addr_mode,
    input logic uninit_wreg,
    input logic security_violation,
    input logic s_rvalid,
    input logic [RSC_DATA_W-1:0] s_rdata,
    input logic system_reset,
    input logic watchdog_enable,
    input logic regulator_sleep_active
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic core_any; // Any source in the clock domain
    logic quiet; // No source at all
    logic [2:0] quiet_q; // Saturating count of quiet cycles
    assign core_any = sw_reset_instr | watchdog_timeout | config_mismatch | trap_conflict | illegal_opcode
        | illegal_addr_mode | uninit_wreg | security_violation;
    assign quiet = !core_any && master_clear_pin_n && !brown_out_detect;
    // Counts cycles without any source, covering the synchroniser delay
    always_ff @(posedge aclk) begin
        if (!aresetn || !quiet) begin
            quiet_q <= 3'h0;
        end else if (quiet_q != 3'h7) begin
            quiet_q <= quiet_q + 3'h1;
        end
    end
    ////////////////////////////////////////
    property p_core_rst; core_any |=> system_reset; endproperty
    a_core_rst: assert property (p_core_rst) else $error("core source gave no reset");
    property p_pin_rst; (!master_clear_pin_n) [*3] |=> system_reset; endproperty
    a_pin_rst: assert property (p_pin_rst) else $error("pin gave no reset");
    property p_bor_rst; brown_out_detect [*3] |=> system_reset; endproperty
    a_bor_rst: assert property (p_bor_rst) else $error("brown-out gave no reset");
    property p_quiet; quiet_q >= 3'h4 |-> !system_reset; endproperty
    a_quiet: assert property (p_quiet) else $error("reset without source");
    property p_drop; $fell(system_reset) |-> !$past(core_any); endproperty
    a_drop: assert property (p_drop) else $error("reset dropped with source active");
    property p_rsv; s_rvalid |-> s_rdata[31:16] == 16'h0 && s_rdata[13:10] == 4'h0; endproperty
    a_rsv: assert property (p_rsv) else $error("unimplemented bits read nonzero");
    property p_fuse; watchdog_fuse_enable [*3] |=> watchdog_enable; endproperty
    a_fuse: assert property (p_fuse) else $error("fuse did not force watchdog");
    property p_ctl; system_reset [*3] |-> !regulator_sleep_active; endproperty
    a_ctl: assert property (p_ctl) else $error("regulator control kept in reset");
endmodule
bind rsc_reset_combiner rsc_checker u_checker (.aclk, .aresetn, .master_clear_pin_n, .brown_out_detect,
    .watchdog_fuse_enable, .sw_reset_instr, .watchdog_timeout, .config_mismatch, .trap_conflict,
    .illegal_opcode, .illegal_addr_mode, .uninit_wreg, .security_violation, .s_rvalid, .s_rdata,
    .system_reset, .watchdog_enable, .regulator_sleep_active);

// ==== tb/testbench.sv ====
// Self-checking bench for the reset source combiner over AXI4-Lite.
// Assumes the source model turns request bits into source levels.
`timescale 1ns/1ps
module testbench;
    import rsc_pkg::*;
    logic aclk = 1'b0; // System clock
    logic aresetn = 1'b0; // Power-on reset, active low
    logic [12:0] req = 13'h0; // Source requests
    logic [7:0] s_awaddr = 8'h0, s_araddr = 8'h0;
    logic [31:0] s_wdata = 32'h0;
    logic [3:0] s_wstrb = 4'h0;
    logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, system_reset, watchdog_enable;
    logic regulator_sleep_active, master_clear_pin_n, brown_out_detect, watchdog_fuse_enable;
    logic sw_reset_instr, watchdog_timeout, config_mismatch, trap_conflict, illegal_opcode;
    logic illegal_addr_mode, uninit_wreg, security_violation, sleep_entered, idle_entered;
    logic [1:0] s_bresp, s_rresp;
    logic [31:0] s_rdata;
    int err_total = 0; // Mismatches
    int num_checks = 0; // Comparisons
    int flag_bit [12] = '{7, 1, 6, 4, 9, 15, 14, 14, 14, 14, 3, 2}; // Flag set by each request
    // Free-running clock, 50 ns period
    initial forever #25 aclk = ~aclk;
    rsc_src_model model (.req, .master_clear_pin_n, .brown_out_detect, .sw_reset_instr, .watchdog_timeout,
        .config_mismatch, .trap_conflict, .illegal_opcode, .illegal_addr_mode, .uninit_wreg,
        .security_violation, .sleep_entered, .idle_entered, .watchdog_fuse_enable);
    rsc_reset_combiner dut (.aclk, .aresetn, .master_clear_pin_n, .brown_out_detect, .watchdog_fuse_enable,
        .sw_reset_instr, .watchdog_timeout, .config_mismatch, .trap_conflict, .illegal_opcode,
        .illegal_addr_mode, .uninit_wreg, .security_violation, .sleep_entered, .idle_entered, .s_awaddr,
        .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready,
        .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .system_reset,
        .watchdog_enable, .regulator_sleep_active);
    ////////////////////////////////////////
    // Verdict and end of run
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Compare one value
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Ends the run when a bus answer never comes
    task automatic bound(input int n);
        if (n > 40) begin
            err_total++;
            $display("mismatch bus answer expected in 40 cycles");
            final_report();
        end
    endtask
    // One write; address and data offered together, response awaited
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        int n;
        logic done;
        n = 0;
        done = 1'b0;
        @(posedge aclk);
        s_awaddr <= a;
        s_wdata <= d;
        s_wstrb <= s;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            n++;
            bound(n);
            if (s_awready) s_awvalid <= 1'b0;
            if (s_wready) s_wvalid <= 1'b0;
            if (s_bvalid) begin
                done = 1'b1;
                chk("bresp", 32'(s_bresp), 32'(er));
            end
        end
        s_bready <= 1'b0;
    endtask
    // One read, data and response compared
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        logic done;
        n = 0;
        done = 1'b0;
        @(posedge aclk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            n++;
            bound(n);
            if (s_arready) s_arvalid <= 1'b0;
            if (s_rvalid) begin
                done = 1'b1;
                chk("rdata", s_rdata, ed);
                chk("rresp", 32'(s_rresp), 32'(er));
            end
        end
        s_rready <= 1'b0;
    endtask
    // Raise one source for four cycles, then let it settle
    task automatic fire(input int i);
        req[i] <= 1'b1;
        repeat (4) @(posedge aclk);
        chk("system_reset", 32'(system_reset), 32'(i < 10));
        req[i] <= 1'b0;
        repeat (4) @(posedge aclk);
        chk("system_reset", 32'(system_reset), 32'h0);
    endtask
    ////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(8'h00, 32'h0003, 2'h0);
        chk("system_reset", 32'(system_reset), 32'h0);
        rd(8'h44, 32'h0, 2'h2);
        rd(8'h04, 32'h0, 2'h0);
        // Software sets every implemented bit, no reset follows
        wr(8'h00, 32'hffff_ffff, 4'hf, 2'h0);
        rd(8'h00, 32'hc3ff, 2'h0);
        chk("system_reset", 32'(system_reset), 32'h0);
        chk("regulator_sleep_active", 32'(regulator_sleep_active), 32'h1);
        chk("watchdog_enable", 32'(watchdog_enable), 32'h1);
        // Low byte lane only, then ignored and refused writes
        wr(8'h00, 32'h0, 4'h1, 2'h0);
        wr(8'h04, 32'hffff, 4'hf, 2'h0);
        wr(8'h44, 32'h0, 4'hf, 2'h2);
        rd(8'h00, 32'hc300, 2'h0);
        wr(8'h00, 32'h0, 4'hf, 2'h0);
        chk("regulator_sleep_active", 32'(regulator_sleep_active), 32'h0);
        chk("watchdog_enable", 32'(watchdog_enable), 32'h0);
        // Each source sets its own flag
        for (int i = 0; i < 12; i++) begin
            fire(i);
            rd(8'h00, 32'h1 << flag_bit[i], 2'h0);
            wr(8'h00, 32'h0, 4'hf, 2'h0);
        end
        // Unprogrammed fuse forces the watchdog on
        req[12] <= 1'b1;
        repeat (4) @(posedge aclk);
        chk("watchdog_enable", 32'(watchdog_enable), 32'h1);
        req[12] <= 1'b0;
        // Controls forced in reset; hardware flag beats software clear
        wr(8'h00, 32'h0120, 4'hf, 2'h0);
        req[5] <= 1'b1;
        repeat (4) @(posedge aclk);
        chk("regulator_sleep_active", 32'(regulator_sleep_active), 32'h0);
        wr(8'h00, 32'h0, 4'hf, 2'h0);
        rd(8'h00, 32'h8000, 2'h0);
        rd(8'h04, 32'h0020, 2'h0);
        req[5] <= 1'b0;
        repeat (3) @(posedge aclk);
        chk("system_reset", 32'(system_reset), 32'h0);
        // Second power-on clears all flags but the power-on and brown-out ones
        wr(8'h00, 32'hc3fc, 4'hf, 2'h0);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(8'h00, 32'h0003, 2'h0);
        final_report();
    end
endmodule
